// >>> include/daq_io_pkg.sv
package daq_io_pkg;

  // byte I/O window on the card side
  localparam int IO_ADDR_W = 16;
  localparam int IO_DATA_W = 8;
  typedef logic [IO_DATA_W-1:0] io_byte_t;
  typedef logic [IO_ADDR_W-1:0] io_addr_t;

  // card register offsets from io_base_address
  localparam logic [7:0] OFS_DIO_RESET   = 8'h00;
  localparam logic [7:0] OFS_AUX_CONTROL = 8'h02;
  localparam logic [7:0] OFS_AUX_DATA    = 8'h03;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h05;
  localparam logic [7:0] OFS_AUX_STATUS  = 8'h07;
  localparam logic [7:0] OFS_IRQ_POL     = 8'h2A;
  localparam logic [7:0] OFS_TIMER_0     = 8'hC0;
  localparam logic [7:0] OFS_TIMER_1     = 8'hC4;
  localparam logic [7:0] OFS_TIMER_2     = 8'hC8;
  localparam logic [7:0] OFS_TIMER_CTRL  = 8'hCC;
  localparam logic [7:0] OFS_CONV_LOW    = 8'hD0;
  localparam logic [7:0] OFS_CONV_HIGH   = 8'hD4;
  localparam logic [7:0] OFS_DIO_LOW     = 8'hD8;
  localparam logic [7:0] OFS_DIO_HIGH    = 8'hDC;
  localparam logic [7:0] OFS_ADC_GAIN    = 8'hE0;
  localparam logic [7:0] OFS_ADC_MODE    = 8'hE4;
  localparam logic [7:0] OFS_ADC_TRIGGER = 8'hE8;
  localparam logic [7:0] OFS_ADC_STATUS  = 8'hEC;

  // field positions
  localparam int DIO_ENABLE_BIT = 0;
  localparam int IRQ_A_BIT      = 0;
  localparam int IRQ_B_BIT      = 1;
  localparam int AUX_EEP_LSB    = 2;
  localparam int BOARD_SUB_IDENTIFIER_LSB     = 4;
  localparam int ADC_READY_BIT  = 0;
  localparam int CONV_HIGH_W    = 4;

  // reset values
  localparam logic       DIO_ENABLE_RST = 1'b0;
  localparam logic [1:0] IRQ_MASK_RST   = 2'b00;
  localparam logic [1:0] IRQ_POL_RST    = 2'b00;
  localparam io_byte_t   BYTE_RST       = 8'h00;

  // host controller registers on APB
  localparam int         APB_ADDR_W     = 12;
  localparam logic [11:0] HOST_ADDR_OFS   = 12'h000;
  localparam logic [11:0] HOST_WDATA_OFS  = 12'h004;
  localparam logic [11:0] HOST_CTRL_OFS   = 12'h008;
  localparam logic [11:0] HOST_STATUS_OFS = 12'h00C;
  localparam logic [11:0] HOST_RDATA_OFS  = 12'h010;
  localparam int CTRL_GO_BIT      = 0;
  localparam int CTRL_WRITE_BIT   = 1;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_DONE_BIT    = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_IRQ_BIT     = 3;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b01,
    HOST_WAIT = 2'b10
  } host_state_e;

endpackage

// >>> include/daq_io_if.sv
interface daq_io_if;
  import daq_io_pkg::*;
  logic     io_req;
  logic     io_write;
  io_addr_t io_addr;
  io_byte_t io_wdata;
  io_byte_t io_rdata;
  logic     io_ack;
  logic     io_irq;

  modport device (
    input  io_req,
    input  io_write,
    input  io_addr,
    input  io_wdata,
    output io_rdata,
    output io_ack,
    output io_irq
  );

  modport host (
    output io_req,
    output io_write,
    output io_addr,
    output io_wdata,
    input  io_rdata,
    input  io_ack,
    input  io_irq
  );
endinterface

// >>> rtl/daq_card_regs.sv
// Functional notes
// - DIO disabled until reset bit set high
// - host sets reset bit before D/A writes
// - mask bit 0 gates source a, default 0
// - mask bit 1 gates source b, upper zero
// - status bits 0/1 show both sources
// - status shows EEPROM state and board id
// - host reads status to find source
// - polarity bit 0: 0 inverts source a
// - polarity bit 1: 0 inverts source b
// - timer counters and write-only control decoded
// - conversion result read as two bytes
// - ready bit shows valid conversion result
// - D/A code taken from two byte writes
// - low byte staged, high write updates latch
// - host writes low byte before high
// - trigger offset write starts a conversion
// - host leaves aux control register alone
// - aux data drives and samples EEPROM pins
//
// Chosen here: the APB slave port.
module daq_card_regs #(
  parameter daq_io_pkg::io_addr_t IO_BASE = 16'hE000,
  // arbitrary board id value
  parameter logic [3:0]           BOARD_SUB_IDENTIFIER = 4'hA
) (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // host side
  daq_io_if.device                         io,
  // interrupt sources
  input  wire logic                        irq_source_a,
  input  wire logic                        irq_source_b,
  // EEPROM
  input  wire logic [1:0]                  eeprom_ctrl_state,
  input  wire daq_io_pkg::io_byte_t        eeprom_sense,
  output      daq_io_pkg::io_byte_t        eeprom_drive,
  output      daq_io_pkg::io_byte_t        aux_control_out,
  // interval timer
  output logic                             timer_wr,
  output logic                             timer_rd,
  output logic [1:0]                       timer_sel,
  output      daq_io_pkg::io_byte_t        timer_wdata,
  input  wire logic [2:0][7:0]             timer_rdata,
  // converter
  output logic                             adc_start,
  input  wire logic                        adc_done,
  input  wire logic [11:0]                 adc_result,
  output      daq_io_pkg::io_byte_t        adc_gain_mux,
  output      daq_io_pkg::io_byte_t        adc_mode,
  output logic [11:0]                      dac_code,
  // digital I/O
  output logic                             dio_enable,
  input  wire logic [15:0]                 di_in,
  output logic [15:0]                      do_out
);
  import daq_io_pkg::*;

  logic       ack_q;
  logic       take;
  logic       in_window;
  logic       wr;
  logic [7:0] ofs;
  logic [1:0] irq_unmask;
  logic [1:0] irq_pass;
  logic       cond_a;
  logic       cond_b;
  io_byte_t   dac_stage;
  logic       adc_ready;
  logic [11:0] adc_data;
  io_byte_t   rdata;
  io_byte_t   next_rdata;

  // one access per request; ack blocks a second take of the same one
  assign take      = io.io_req && !ack_q;
  assign in_window = io.io_addr[15:8] == IO_BASE[15:8];
  assign wr        = take && in_window && io.io_write;
  assign ofs       = io.io_addr[7:0];
  assign io.io_ack   = ack_q;
  assign io.io_rdata = rdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dio_enable      <= DIO_ENABLE_RST;
      aux_control_out <= BYTE_RST;
      eeprom_drive    <= BYTE_RST;
      irq_unmask      <= IRQ_MASK_RST;
      irq_pass        <= IRQ_POL_RST;
      adc_gain_mux    <= BYTE_RST;
      adc_mode        <= BYTE_RST;
    end else if (wr) begin
      if (ofs == OFS_DIO_RESET) begin
        dio_enable <= io.io_wdata[DIO_ENABLE_BIT];
      end else if (ofs == OFS_AUX_CONTROL) begin
        aux_control_out <= io.io_wdata;
      end else if (ofs == OFS_AUX_DATA) begin
        eeprom_drive <= io.io_wdata;
      end else if (ofs == OFS_IRQ_MASK) begin
        irq_unmask <= io.io_wdata[IRQ_B_BIT:IRQ_A_BIT];
      end else if (ofs == OFS_IRQ_POL) begin
        irq_pass <= io.io_wdata[IRQ_B_BIT:IRQ_A_BIT];
      end else if (ofs == OFS_ADC_GAIN) begin
        adc_gain_mux <= io.io_wdata;
      end else if (ofs == OFS_ADC_MODE) begin
        adc_mode <= io.io_wdata;
      end
    end
  end

  // digital outputs are held cleared while DIO is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_out <= 16'h0000;
    end else if (!dio_enable) begin
      do_out <= 16'h0000;
    end else if (wr && ofs == OFS_DIO_LOW) begin
      do_out[7:0] <= io.io_wdata;
    end else if (wr && ofs == OFS_DIO_HIGH) begin
      do_out[15:8] <= io.io_wdata;
    end
  end

  // double-buffered D/A latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_stage <= BYTE_RST;
      dac_code  <= 12'h000;
    end else if (wr && ofs == OFS_CONV_LOW) begin
      dac_stage <= io.io_wdata;
    end else if (wr && ofs == OFS_CONV_HIGH) begin
      dac_code <= {io.io_wdata[CONV_HIGH_W-1:0], dac_stage};
    end
  end

  // conversion completion beats a trigger in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_ready <= 1'b0;
      adc_data  <= 12'h000;
      adc_start <= 1'b0;
    end else begin
      adc_start <= wr && ofs == OFS_ADC_TRIGGER;
      if (adc_done) begin
        adc_ready <= 1'b1;
        adc_data  <= adc_result;
      end else if (wr && ofs == OFS_ADC_TRIGGER) begin
        adc_ready <= 1'b0;
      end
    end
  end

  // timer strobes one cycle after the access is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_wr    <= 1'b0;
      timer_rd    <= 1'b0;
      timer_sel   <= 2'b00;
      timer_wdata <= BYTE_RST;
    end else begin
      timer_wr <= 1'b0;
      timer_rd <= 1'b0;
      if (take && in_window && ofs[7:4] == OFS_TIMER_0[7:4] && ofs[1:0] == 2'b00) begin
        timer_sel   <= ofs[3:2];
        timer_wdata <= io.io_wdata;
        timer_wr    <= io.io_write;
        // control word has no read side
        timer_rd    <= !io.io_write && ofs != OFS_TIMER_CTRL;
      end
    end
  end

  assign cond_a = irq_pass[IRQ_A_BIT] ? irq_source_a : !irq_source_a;
  assign cond_b = irq_pass[IRQ_B_BIT] ? irq_source_b : !irq_source_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io.io_irq <= 1'b0;
    end else begin
      io.io_irq <= (cond_a && irq_unmask[IRQ_A_BIT]) ||
                   (cond_b && irq_unmask[IRQ_B_BIT]);
    end
  end

  always_comb begin
    next_rdata = BYTE_RST;
    if (!in_window) begin
      next_rdata = BYTE_RST;
    end else if (ofs == OFS_DIO_RESET) begin
      next_rdata[DIO_ENABLE_BIT] = dio_enable;
    end else if (ofs == OFS_AUX_CONTROL) begin
      next_rdata = aux_control_out;
    end else if (ofs == OFS_AUX_DATA) begin
      next_rdata = eeprom_sense;
    end else if (ofs == OFS_IRQ_MASK) begin
      next_rdata[IRQ_B_BIT:IRQ_A_BIT] = irq_unmask;
    end else if (ofs == OFS_AUX_STATUS) begin
      next_rdata[IRQ_A_BIT] = irq_source_a;
      next_rdata[IRQ_B_BIT] = irq_source_b;
      next_rdata[AUX_EEP_LSB+1:AUX_EEP_LSB] = eeprom_ctrl_state;
      next_rdata[BOARD_SUB_IDENTIFIER_LSB+3:BOARD_SUB_IDENTIFIER_LSB] = BOARD_SUB_IDENTIFIER;
    end else if (ofs == OFS_IRQ_POL) begin
      next_rdata[IRQ_B_BIT:IRQ_A_BIT] = irq_pass;
    end else if (ofs == OFS_TIMER_0) begin
      next_rdata = timer_rdata[0];
    end else if (ofs == OFS_TIMER_1) begin
      next_rdata = timer_rdata[1];
    end else if (ofs == OFS_TIMER_2) begin
      next_rdata = timer_rdata[2];
    end else if (ofs == OFS_CONV_LOW) begin
      next_rdata = adc_data[7:0];
    end else if (ofs == OFS_CONV_HIGH) begin
      next_rdata[CONV_HIGH_W-1:0] = adc_data[11:8];
    end else if (ofs == OFS_DIO_LOW) begin
      next_rdata = dio_enable ? di_in[7:0] : BYTE_RST;
    end else if (ofs == OFS_DIO_HIGH) begin
      next_rdata = dio_enable ? di_in[15:8] : BYTE_RST;
    end else if (ofs == OFS_ADC_STATUS) begin
      next_rdata[ADC_READY_BIT] = adc_ready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= BYTE_RST;
    end else if (take && !io.io_write) begin
      rdata <= next_rdata;
    end
  end

endmodule // daq_card_regs

// >>> rtl/daq_host_ctrl.sv
module daq_host_ctrl (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // software side
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // card side
  daq_io_if.host                             io
);
  import daq_io_pkg::*;

  host_state_e state;
  io_addr_t    target_addr;
  io_byte_t    target_wdata;
  io_byte_t    read_byte;
  logic        done;
  logic        refused;
  logic        dio_released;
  logic        dac_low_pending;
  logic        apb_wr;
  logic        go;
  logic        go_write;
  logic        forbid;
  logic        finish;
  logic [7:0]  go_ofs;
  logic        mapped;

  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign go       = apb_wr && paddr == HOST_CTRL_OFS && pwdata[CTRL_GO_BIT];
  assign go_write = pwdata[CTRL_WRITE_BIT];
  assign go_ofs   = target_addr[7:0];
  assign finish   = state == HOST_WAIT && io.io_ack;
  assign mapped   = paddr == HOST_ADDR_OFS || paddr == HOST_WDATA_OFS ||
                    paddr == HOST_CTRL_OFS || paddr == HOST_STATUS_OFS ||
                    paddr == HOST_RDATA_OFS;
  assign pslverr  = psel && penable && !mapped;

  // orders the card must not see are dropped here
  assign forbid = go_ofs == OFS_AUX_CONTROL ||
                  (go_write && (go_ofs == OFS_CONV_LOW || go_ofs == OFS_CONV_HIGH) &&
                   !dio_released) ||
                  (go_write && go_ofs == OFS_CONV_HIGH && !dac_low_pending);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_addr  <= 16'h0000;
      target_wdata <= BYTE_RST;
    end else if (apb_wr && paddr == HOST_ADDR_OFS) begin
      target_addr <= pwdata[15:0];
    end else if (apb_wr && paddr == HOST_WDATA_OFS) begin
      target_wdata <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= HOST_IDLE;
      io.io_req   <= 1'b0;
      io.io_write <= 1'b0;
      io.io_addr  <= 16'h0000;
      io.io_wdata <= BYTE_RST;
    end else begin
      case (state)
        HOST_IDLE: begin
          if (go && !forbid) begin
            state       <= HOST_WAIT;
            io.io_req   <= 1'b1;
            io.io_write <= go_write;
            io.io_addr  <= target_addr;
            io.io_wdata <= target_wdata;
          end
        end
        HOST_WAIT: begin
          if (io.io_ack) begin
            state     <= HOST_IDLE;
            io.io_req <= 1'b0;
          end
        end
        default: begin
          state     <= HOST_IDLE;
          io.io_req <= 1'b0;
        end
      endcase
    end
  end

  // shadow of what the card has been told, for the ordering checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dio_released    <= 1'b0;
      dac_low_pending <= 1'b0;
      read_byte       <= BYTE_RST;
    end else if (finish) begin
      if (!io.io_write) begin
        read_byte <= io.io_rdata;
      end else if (io.io_addr[7:0] == OFS_DIO_RESET) begin
        dio_released <= io.io_wdata[DIO_ENABLE_BIT];
      end else if (io.io_addr[7:0] == OFS_CONV_LOW) begin
        dac_low_pending <= 1'b1;
      end else if (io.io_addr[7:0] == OFS_CONV_HIGH) begin
        dac_low_pending <= 1'b0;
      end
    end
  end

  // sticky flags: a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done    <= 1'b0;
      refused <= 1'b0;
    end else begin
      if (finish) begin
        done <= 1'b1;
      end else if (apb_wr && paddr == HOST_STATUS_OFS && pwdata[STAT_DONE_BIT]) begin
        done <= 1'b0;
      end
      if (go && (forbid || state != HOST_IDLE)) begin
        refused <= 1'b1;
      end else if (apb_wr && paddr == HOST_STATUS_OFS && pwdata[STAT_REFUSED_BIT]) begin
        refused <= 1'b0;
      end
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == HOST_ADDR_OFS) begin
      prdata[15:0] = target_addr;
    end else if (paddr == HOST_WDATA_OFS) begin
      prdata[7:0] = target_wdata;
    end else if (paddr == HOST_STATUS_OFS) begin
      prdata[STAT_BUSY_BIT]    = state == HOST_WAIT;
      prdata[STAT_DONE_BIT]    = done;
      prdata[STAT_REFUSED_BIT] = refused;
      // software reads the card's aux status next to learn which source
      prdata[STAT_IRQ_BIT]     = io.io_irq;
    end else if (paddr == HOST_RDATA_OFS) begin
      prdata[7:0] = read_byte;
    end
  end

endmodule // daq_host_ctrl

// >>> verif/daq_io_checker.sv
module daq_io_checker
  import daq_io_pkg::*;
#(
  parameter io_addr_t   IO_BASE  = 16'hE000,
  parameter logic [3:0] BOARD_ID = 4'hA
) (
  // clock and reset
  input wire logic     pclk,
  input wire logic     presetn,
  // card bus
  input wire logic     io_req,
  input wire logic     io_write,
  input wire io_addr_t io_addr,
  input wire io_byte_t io_wdata,
  input wire io_byte_t io_rdata,
  input wire logic     io_ack,
  input wire logic     io_irq
);
  logic [1:0] mask_sh;
  logic [1:0] pol_sh;
  logic       en_sh;
  logic       hit;
  logic       rd;
  logic [7:0] ofs;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign ofs = io_addr[7:0];
  assign hit = io_ack && (io_addr[15:8] == IO_BASE[15:8]);
  assign rd  = hit && !io_write;

  // shadow copies follow the writes seen on the bus, so reads can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_sh <= 2'h0;
      pol_sh  <= 2'h0;
      en_sh   <= 1'b0;
    end else if (hit && io_write) begin
      if (ofs == OFS_IRQ_MASK) mask_sh <= io_wdata[1:0];
      if (ofs == OFS_IRQ_POL) pol_sh <= io_wdata[1:0];
      if (ofs == OFS_DIO_RESET) en_sh <= io_wdata[0];
    end
  end

  AST_ACK_ONE: assert property (io_ack |=> !io_ack)
    else $error("ack longer than one cycle");
  AST_ACK_TIMELY: assert property (io_req && !io_ack |=> io_ack)
    else $error("request not acked next cycle");
  AST_REQ_DROP: assert property (io_ack |=> !io_req)
    else $error("request held after ack");
  AST_REQ_STABLE: assert property (io_req && !io_ack |=>
    $stable(io_addr) && $stable(io_write) && $stable(io_wdata))
    else $error("request changed before ack");
  AST_MASK_RD: assert property (rd && ofs == OFS_IRQ_MASK |-> io_rdata == {6'h00, mask_sh})
    else $error("mask readback wrong");
  AST_POL_RD: assert property (rd && ofs == OFS_IRQ_POL |->
    io_rdata[7:4] == 4'h0 && io_rdata[1:0] == pol_sh)
    else $error("polarity readback wrong");
  AST_DIO_RD: assert property (rd && ofs == OFS_DIO_RESET |-> io_rdata[0] == en_sh)
    else $error("dio reset bit readback wrong");
  AST_ID_RD: assert property (rd && ofs == OFS_AUX_STATUS |-> io_rdata[7:4] == BOARD_ID)
    else $error("board id field wrong");
  AST_HIGH_RD: assert property (rd && ofs == OFS_CONV_HIGH |-> io_rdata[7:4] == 4'h0)
    else $error("result high byte upper bits set");
  AST_WO_RD: assert property (rd && (ofs == OFS_TIMER_CTRL || ofs == OFS_ADC_TRIGGER)
    |-> io_rdata == 8'h00)
    else $error("write-only offset read nonzero");
  AST_IRQ_OFF: assert property (mask_sh == 2'h0 && $past(mask_sh) == 2'h0 |-> !io_irq)
    else $error("irq with both sources masked");

  COV_STATUS: cover property (rd && ofs == OFS_AUX_STATUS);
  COV_IRQ: cover property ($rose(io_irq));
  COV_DAC: cover property (hit && io_write && ofs == OFS_CONV_HIGH);
endmodule // daq_io_checker

// >>> verif/daq_card_io_register_map_tb.sv
module daq_card_io_register_map_tb import daq_io_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam io_addr_t   BASE = 16'hE000;
  localparam logic [3:0] ID   = 4'h5; // arbitrary board id
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, d;
  logic            src_a, src_b, adc_done, timer_wr, timer_rd, adc_start, dio_enable, f, e;
  logic [1:0]      eep_st, timer_sel, t_sel;
  io_byte_t        eep_sense, eep_drive, aux_out, timer_wdata, gain, mode, r, t_wd, o;
  logic [2:0][7:0] timer_rdata;
  logic [11:0]     adc_result, dac_code;
  logic [15:0]     di_in, do_out, rnd;
  int              failures, n_compared, n_start, n_rd;

  daq_io_if u_daq_io_if ();
  daq_host_ctrl u_daq_host_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io(u_daq_io_if));
  daq_card_regs #(.IO_BASE(BASE), .BOARD_SUB_IDENTIFIER(ID)) u_daq_card_regs (.pclk(pclk),
    .presetn(presetn), .io(u_daq_io_if), .irq_source_a(src_a), .irq_source_b(src_b),
    .eeprom_ctrl_state(eep_st), .eeprom_sense(eep_sense), .eeprom_drive(eep_drive),
    .aux_control_out(aux_out), .timer_wr(timer_wr), .timer_rd(timer_rd), .timer_sel(timer_sel),
    .timer_wdata(timer_wdata), .timer_rdata(timer_rdata), .adc_start(adc_start),
    .adc_done(adc_done), .adc_result(adc_result), .adc_gain_mux(gain), .adc_mode(mode),
    .dac_code(dac_code), .dio_enable(dio_enable), .di_in(di_in), .do_out(do_out));
  daq_io_checker #(.IO_BASE(BASE), .BOARD_ID(ID)) u_daq_io_checker (.pclk(pclk),
    .presetn(presetn), .io_req(u_daq_io_if.io_req), .io_write(u_daq_io_if.io_write),
    .io_addr(u_daq_io_if.io_addr), .io_wdata(u_daq_io_if.io_wdata),
    .io_rdata(u_daq_io_if.io_rdata), .io_ack(u_daq_io_if.io_ack), .io_irq(u_daq_io_if.io_irq));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // pulses last one cycle, so they are caught here rather than polled
  always @(posedge pclk) begin
    if (timer_wr === 1'b1) begin
      t_sel <= timer_sel;
      t_wd  <= timer_wdata;
    end
    if (adc_start === 1'b1) n_start <= n_start + 1;
    if (timer_rd === 1'b1) n_rd <= n_rd + 1;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // pass bit high leaves the source as is, low inverts it
  function automatic logic exp_irq(input logic [1:0] m, p, input logic a, b);
    return (m[0] & (a ~^ p[0])) | (m[1] & (b ~^ p[1]));
  endfunction

  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      failures++;
      conclude();
    end
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic io(input logic w, input logic [7:0] ofs, input logic [7:0] wd);
    int n;
    apb(1'b1, HOST_ADDR_OFS, {16'h0000, BASE[15:8], ofs});
    apb(1'b1, HOST_WDATA_OFS, {24'h000000, wd});
    apb(1'b1, HOST_CTRL_OFS, 32'((w << CTRL_WRITE_BIT) | (1 << CTRL_GO_BIT)));
    for (n = 0; n < 16; n++) begin
      apb(1'b0, HOST_STATUS_OFS, 32'h0);
      if (d[STAT_DONE_BIT] | d[STAT_REFUSED_BIT]) break;
    end
    if (n == 16) begin
      failures++;
      conclude();
    end
    f = d[STAT_REFUSED_BIT];
    apb(1'b1, HOST_STATUS_OFS, 32'((1 << STAT_DONE_BIT) | (1 << STAT_REFUSED_BIT)));
    apb(1'b0, HOST_RDATA_OFS, 32'h0);
    r = d[7:0];
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; src_a = 1'b0; src_b = 1'b0; adc_done = 1'b0; adc_result = 12'h000;
    eep_st = 2'h2; eep_sense = 8'h5C; di_in = 16'hBEEF; timer_rdata = {8'h33, 8'h22, 8'h11};
    n_start = 0; n_rd = 0; failures = 0; n_compared = 0; rnd = 16'hA702;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(dio_enable, 1'b0);
    io(1'b0, OFS_DIO_RESET, 8'h00); chk(r, 8'h00);
    io(1'b0, OFS_IRQ_MASK, 8'h00); chk(r, 8'h00);
    io(1'b0, OFS_IRQ_POL, 8'h00); chk(r, 8'h00);
    io(1'b1, OFS_DIO_LOW, 8'hA5); chk(do_out, 16'h0000);
    io(1'b1, OFS_CONV_LOW, 8'h12); chk(f, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      io(1'b1, OFS_IRQ_MASK, {6'h00, i[1:0]});
      io(1'b1, OFS_IRQ_POL, {6'h00, i[3:2]});
      src_a <= rnd[0];
      src_b <= rnd[1];
      io(1'b0, OFS_AUX_STATUS, 8'h00); chk(r, {ID, eep_st, rnd[1:0]});
      apb(1'b0, HOST_STATUS_OFS, 32'h0);
      chk({e, d[STAT_IRQ_BIT]}, {1'b0, exp_irq(i[1:0], i[3:2], rnd[0], rnd[1])});
    end
    $display("test irq done");
    io(1'b1, OFS_DIO_RESET, 8'h01); chk(dio_enable, 1'b1);
    io(1'b1, OFS_DIO_LOW, 8'hA5); chk(do_out[7:0], 8'hA5);
    io(1'b0, OFS_DIO_LOW, 8'h00); chk(r, 8'hEF);
    io(1'b1, OFS_CONV_HIGH, 8'h07); chk(f, 1'b1);
    rnd = lfsr(rnd);
    io(1'b1, OFS_CONV_LOW, rnd[7:0]); chk(dac_code, 12'h000);
    io(1'b1, OFS_CONV_HIGH, {4'hF, rnd[11:8]}); chk(dac_code, rnd[11:0]);
    $display("test dac done");
    io(1'b1, OFS_ADC_TRIGGER, 8'h00); chk(n_start, 1);
    io(1'b0, OFS_ADC_STATUS, 8'h00); chk(r[ADC_READY_BIT], 1'b0);
    rnd = lfsr(rnd);
    @(posedge pclk);
    adc_done   <= 1'b1;
    adc_result <= rnd[11:0];
    @(posedge pclk);
    adc_done <= 1'b0;
    io(1'b0, OFS_ADC_STATUS, 8'h00); chk(r[ADC_READY_BIT], 1'b1);
    io(1'b0, OFS_CONV_LOW, 8'h00); chk(r, rnd[7:0]);
    io(1'b0, OFS_CONV_HIGH, 8'h00); chk(r, {4'h0, rnd[11:8]});
    rnd = lfsr(rnd);
    io(1'b1, OFS_ADC_GAIN, rnd[7:0]);
    io(1'b1, OFS_ADC_MODE, rnd[15:8]);
    // a second trigger must pull a ready flag that is already set back to zero
    io(1'b1, OFS_ADC_TRIGGER, 8'h00);
    io(1'b0, OFS_ADC_STATUS, 8'h00);
    chk({gain, mode, n_start[1:0], r[ADC_READY_BIT]}, {rnd[7:0], rnd[15:8], 2'd2, 1'b0});
    $display("test adc done");
    for (int k = 0; k < 4; k++) begin
      o = 8'(OFS_TIMER_0 + 4 * k);
      io(1'b1, o, 8'(8'h40 + k)); chk({t_sel, t_wd}, {k[1:0], 8'(8'h40 + k)});
      io(1'b0, o, 8'h00); chk(r, (k < 3) ? timer_rdata[k] : 8'h00);
    end
    chk(n_rd, 3);
    io(1'b1, OFS_AUX_DATA, 8'h96); chk(eep_drive, 8'h96);
    io(1'b0, OFS_AUX_DATA, 8'h00); chk(r, eep_sense);
    io(1'b1, OFS_AUX_CONTROL, 8'h01); chk({f, aux_out}, {1'b1, 8'h00});
    $display("test timer and aux done");
    conclude();
  end
endmodule // daq_card_io_register_map_tb
